// File: rtl/ddrci_top.sv
/*
 ddr3 command/control input block: samples command, address, clock enable,
 termination control on the link clock and byte masks on the strobe clock, and reports decoded
 commands and power state to the core on mclk_i.
 assumes link_clk_i is the controller's clock pair recovered as one clock, and
 the strobe edge as a separate clock port, and a controller obeying the bus.
*/
//
// What this block does
// - capture command inputs on rising true clock edge
// - clock enable low stops clocks and drivers
// - idle banks give precharge powerdown or self refresh
// - clock enable exits self refresh asynchronously
// - power states gate input buffers
// - chip select high masks the command
// - command decoded from four strobes together
// - registered termination high enables termination
// - termination applies to data pins only
// - termination ignored when mode register disables
// - masked beats are discarded
// - masks sampled on both strobe edges
// - bank bits pick bank or mode register
// - address carries row, column or opcode
// - auto_precharge_bit closes bank with the read or write command
// - precharge closes all banks when bit high
// - burst_chop_bit low chops the burst
// - active low asynchronous reset enters reset
// - differential strobe only, edge aligned reads
`timescale 1ns/1ns
module ddrci_top
   import ddrci_pkg::*;
#(
   parameter int NBANK = DDRCI_NBANK
)(
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic link_clk_i,
   input wire logic strobe_clk_i,
   input wire logic reset_n_i,
   input wire logic cke_i,
   input wire logic odt_i,
   input wire ddrci_ca_t ca_i,
   input wire logic lower_byte_write_mask_i,
   input wire logic upper_byte_write_mask_i,
   output ddrci_cmd_t cmd_o,
   output logic [3:0] beat_keep_o,
   output logic link_active_o,
   output logic buffers_on_o,
   output logic term_on_o,
   output logic term_data_pins_o,
   output logic [NBANK-1:0] bank_open_o,
   output logic [1:0] power_state_o,
   output logic in_reset_o
);

   // reset release synchroniser in the link domain, assert is asynchronous
   // async low reset
   logic lrst_m_r, lrst_r;
   always_ff @(posedge link_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         lrst_m_r <= 1'b1;
         lrst_r <= 1'b1;
      end
      else
      begin
         lrst_m_r <= 1'b0;
         lrst_r <= lrst_m_r;
      end
   end

   // next-state and bank tracking in the link domain
   ddrci_state_t st_r, st_nxt;
   logic [NBANK-1:0] open_r, open_nxt;
   logic odt_en_r, odt_en_nxt;
   logic term_r, term_nxt;
   ddrci_cmd_t lcmd_r, lcmd_nxt;
   logic ltog_r, ltog_nxt;
   logic [2:0] code;
   logic is_sref;
   // self refresh exit: cke rise caught by its own edge, then brought over
   logic sref_req_r;
   logic [1:0] sref_sync_r, sref_sync_nxt;
   logic sref_clr_r, sref_clr_nxt;

   function automatic logic [NBANK-1:0] bank_bit(input logic [DDRCI_BANK_W-1:0] b);
      bank_bit = '0;
      bank_bit[b] = 1'b1;
   endfunction : bank_bit

   assign code = {ca_i.ras_n, ca_i.cas_n, ca_i.we_n};
   assign is_sref = (code == DDRCI_CMD_REF);

   always_comb
   begin
      st_nxt = st_r;
      open_nxt = open_r;
      odt_en_nxt = odt_en_r;
      term_nxt = term_r;
      lcmd_nxt = lcmd_r;
      lcmd_nxt.valid = 1'b0;
      ltog_nxt = ltog_r;
      case (st_r)
         DDRCI_ST_RUN:
         begin
            if (!cke_i)
            begin
               if (open_r != '0)
                  st_nxt = DDRCI_ST_APD;
               else if (!ca_i.cs_n && is_sref)
                  st_nxt = DDRCI_ST_SREF;
               else
                  st_nxt = DDRCI_ST_PPD;
            end
            else if (!ca_i.cs_n && code != DDRCI_CMD_NOP)
            begin
               lcmd_nxt.valid = 1'b1;
               lcmd_nxt.code = code;
               lcmd_nxt.bank = ca_i.bank;
               lcmd_nxt.addr = ca_i.addr;
               lcmd_nxt.auto_pre = ca_i.addr[DDRCI_AP_POS];
               lcmd_nxt.chop = !ca_i.addr[DDRCI_BC_POS];
               ltog_nxt = !ltog_r;
               case (code)
                  DDRCI_CMD_ACT: open_nxt = open_r | bank_bit(ca_i.bank);
                  DDRCI_CMD_PRE:
                     open_nxt = ca_i.addr[DDRCI_AP_POS] ? '0 : (open_r & ~bank_bit(ca_i.bank));
                  DDRCI_CMD_RD, DDRCI_CMD_WR:
                     if (ca_i.addr[DDRCI_AP_POS])
                        open_nxt = open_r & ~bank_bit(ca_i.bank);
                  DDRCI_CMD_MRS:
                     if (ca_i.bank == DDRCI_MR_IDX_ODT)
                        odt_en_nxt = ca_i.addr[DDRCI_MR_ODT_POS];
                  default: ;
               endcase
            end
         end
         // only cke and odt seen in power down
         DDRCI_ST_APD, DDRCI_ST_PPD:
            if (cke_i)
               st_nxt = DDRCI_ST_RUN;
         // leave once the captured cke rise is through
         DDRCI_ST_SREF:
            if (sref_sync_r[1])
               st_nxt = DDRCI_ST_RUN;
         default: st_nxt = DDRCI_ST_RUN;
      endcase
      term_nxt = (st_r != DDRCI_ST_SREF) && odt_en_r && odt_i;
      // first stage takes the raw capture, second only counts in self refresh
      sref_sync_nxt = {(st_nxt == DDRCI_ST_SREF) && sref_sync_r[0], sref_req_r};
      // hold the capture flop clear outside self refresh
      sref_clr_nxt = (st_nxt != DDRCI_ST_SREF);
   end

   always_ff @(posedge link_clk_i)
   begin
      if (lrst_r)
      begin
         st_r <= DDRCI_ST_RUN;
         open_r <= '0;
         odt_en_r <= 1'b0;
         term_r <= 1'b0;
         lcmd_r <= '0;
         ltog_r <= 1'b0;
         sref_sync_r <= 2'h0;
         sref_clr_r <= 1'b1;
      end
      else
      begin
         st_r <= st_nxt;
         open_r <= open_nxt;
         odt_en_r <= odt_en_nxt;
         term_r <= term_nxt;
         lcmd_r <= lcmd_nxt;
         ltog_r <= ltog_nxt;
         sref_sync_r <= sref_sync_nxt;
         sref_clr_r <= sref_clr_nxt;
      end
   end

   // self refresh exit seen without clock edge
   // the rising cke clocks this flop itself, so no link edge is needed to catch it
   always_ff @(posedge cke_i or posedge sref_clr_r)
   begin
      if (sref_clr_r)
         sref_req_r <= 1'b0;
      else
         sref_req_r <= 1'b1;
   end

   // strobe pair arrives as one differential clock
   // both masks on both strobe edges
   logic [1:0] mask_rise_r, mask_fall_r;
   always_ff @(posedge strobe_clk_i)
      mask_rise_r <= {upper_byte_write_mask_i, lower_byte_write_mask_i};
   always_ff @(negedge strobe_clk_i)
      mask_fall_r <= {upper_byte_write_mask_i, lower_byte_write_mask_i};

   // crossing into mclk: toggle for commands, two flops for levels
   logic [2:0] tog_s_r;
   logic [2:0] st_m_r, st_s_r;
   logic [1:0] term_s_r;
   logic [1:0] rst_s_r;
   logic [3:0] mk_m_r, mk_s_r;
   logic [NBANK-1:0] open_m_r, open_s_r;
   logic [2:0] st_enc;
   logic [1:0] st_core;
   // one bit flips per state change, so the two flops never see a torn code
   assign st_enc = (st_r == DDRCI_ST_APD) ? 3'h1 : (st_r == DDRCI_ST_PPD) ? 3'h2 :
                   (st_r == DDRCI_ST_SREF) ? 3'h4 : 3'h0;
   // back to 0 run, 1 active pd, 2 precharge pd, 3 self refresh
   assign st_core = st_s_r[2] ? 2'h3 : st_s_r[1] ? 2'h2 : st_s_r[0] ? 2'h1 : 2'h0;
   always_ff @(posedge mclk_i)
   begin
      tog_s_r <= {tog_s_r[1:0], ltog_r};
      st_m_r <= st_enc;
      st_s_r <= st_m_r;
      term_s_r <= {term_s_r[0], term_r};
      rst_s_r <= {rst_s_r[0], lrst_r};
      mk_m_r <= {mask_fall_r[1], mask_rise_r[1], mask_fall_r[0], mask_rise_r[0]};
      mk_s_r <= mk_m_r;
      open_m_r <= open_r;
      open_s_r <= open_m_r;
   end

   // core-side outputs, all registered
   ddrci_cmd_t cmd_nxt;
   always_comb
   begin
      // fields are copied only when the toggle says they are settled
      cmd_nxt = cmd_o;
      cmd_nxt.valid = tog_s_r[2] ^ tog_s_r[1];
      if (cmd_nxt.valid)
      begin
         cmd_nxt = lcmd_r;
         cmd_nxt.valid = 1'b1;
      end
   end
   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         cmd_o <= '0;
         beat_keep_o <= 4'h0;
         link_active_o <= 1'b0;
         buffers_on_o <= 1'b0;
         term_on_o <= 1'b0;
         term_data_pins_o <= 1'b0;
         bank_open_o <= '0;
         power_state_o <= 2'h0;
         in_reset_o <= 1'b1;
      end
      else
      begin
         cmd_o <= cmd_nxt;
         beat_keep_o <= ~mk_s_r;
         // clocks and drivers follow run state
         link_active_o <= (st_core == 2'h0) && !rst_s_r[1];
         buffers_on_o <= (st_core == 2'h0);
         term_on_o <= term_s_r[1];
         term_data_pins_o <= term_s_r[1];
         bank_open_o <= open_s_r;
         power_state_o <= st_core;
         in_reset_o <= rst_s_r[1];
      end
   end

   // assertions, link domain
   // masked command
   a_cs_mask: assert property (@(posedge link_clk_i) disable iff (lrst_r)
      (ca_i.cs_n || st_r != DDRCI_ST_RUN) |=> !lcmd_r.valid) else $error("command taken with cs high");
   a_pre_all: assert property (@(posedge link_clk_i) disable iff (lrst_r)
      (st_r == DDRCI_ST_RUN && cke_i && !ca_i.cs_n && code == DDRCI_CMD_PRE && ca_i.addr[DDRCI_AP_POS])
      |=> open_r == '0) else $error("precharge all left a bank open");
   a_apd_entry: assert property (@(posedge link_clk_i) disable iff (lrst_r)
      (st_r == DDRCI_ST_RUN && !cke_i && open_r != '0) |=> st_r == DDRCI_ST_APD)
      else $error("open bank did not give active power down");
   a_odt_ignore: assert property (@(posedge link_clk_i) disable iff (lrst_r)
      !odt_en_r |=> !term_r) else $error("termination on while disabled");
   a_chop_bit: assert property (@(posedge link_clk_i) disable iff (lrst_r)
      (st_r == DDRCI_ST_RUN && cke_i && !ca_i.cs_n && code == DDRCI_CMD_RD)
      |=> lcmd_r.valid && lcmd_r.chop == !$past(ca_i.addr[DDRCI_BC_POS])) else $error("burst chop wrong");
   a_auto_pre: assert property (@(posedge link_clk_i) disable iff (lrst_r)
      (st_r == DDRCI_ST_RUN && cke_i && !ca_i.cs_n && (code == DDRCI_CMD_WR || code == DDRCI_CMD_RD)
      && ca_i.addr[DDRCI_AP_POS])
      |=> !open_r[$past(ca_i.bank)]) else $error("auto precharge left bank open");
   // assertions, core domain
   // drivers off outside run
   a_drv_off: assert property (@(posedge mclk_i) disable iff (srst_i)
      (st_s_r != 3'h0) |=> !link_active_o && !buffers_on_o) else $error("drivers on in power down");
   a_mask_keep: assert property (@(posedge mclk_i) disable iff (srst_i)
      (mk_s_r != 4'h0) |=> (beat_keep_o & $past(mk_s_r)) == 4'h0) else $error("masked beat kept");
endmodule : ddrci_top

// File: rtl/ddrci_pkg.sv
/*
 package for the ddr3 command input block: command codes, field layouts,
 carrier structs and state enum. assumes nothing of its surroundings.
*/
package ddrci_pkg;
   localparam int DDRCI_BANK_W = 3;
   localparam int DDRCI_ADDR_W = 14;
   localparam int DDRCI_NBANK = 8;
   localparam int DDRCI_AP_POS = 10;
   localparam int DDRCI_BC_POS = 12;
   localparam int DDRCI_MR_ODT_POS = 2;
   localparam int DDRCI_BURST_FULL = 4;
   localparam int DDRCI_BURST_CHOP = 2;
   localparam logic [2:0] DDRCI_MR_IDX_ODT = 3'h1;
   // {ras_n,cas_n,we_n} with cs_n low
   localparam logic [2:0] DDRCI_CMD_MRS = 3'h0;
   localparam logic [2:0] DDRCI_CMD_REF = 3'h1;
   localparam logic [2:0] DDRCI_CMD_PRE = 3'h2;
   localparam logic [2:0] DDRCI_CMD_ACT = 3'h3;
   localparam logic [2:0] DDRCI_CMD_WR = 3'h4;
   localparam logic [2:0] DDRCI_CMD_RD = 3'h5;
   localparam logic [2:0] DDRCI_CMD_NOP = 3'h7;

   typedef enum {DDRCI_ST_RUN, DDRCI_ST_APD, DDRCI_ST_PPD, DDRCI_ST_SREF} ddrci_state_t;

   // command and address pins sampled on the link clock
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [DDRCI_BANK_W-1:0] bank;
      logic [DDRCI_ADDR_W-1:0] addr;
   } ddrci_ca_t;

   // decoded command report toward the core
   typedef struct packed {
      logic valid;
      logic [2:0] code;
      logic [DDRCI_BANK_W-1:0] bank;
      logic [DDRCI_ADDR_W-1:0] addr;
      logic auto_pre;
      logic chop;
   } ddrci_cmd_t;
endpackage : ddrci_pkg

// File: bench/ddrci_ctrl_model.sv
/*
 controller model: makes the clock pair and the write strobe, drives command,
 clock enable, termination, reset and byte masks. assumes the bench calls its
 tasks from one process, one at a time.
*/
`timescale 1ns/1ns
module ddrci_ctrl_model
   import ddrci_pkg::*;
(
   output logic link_clk_o,
   output logic strobe_clk_o,
   output logic reset_n_o,
   output logic cke_o,
   output logic odt_o,
   output ddrci_ca_t ca_o,
   output logic lmask_o,
   output logic umask_o
);
   // free running clock pair, strobe still outside writes
   initial
   begin
      link_clk_o = 1'b0;
      strobe_clk_o = 1'b0;
      reset_n_o = 1'b0;
      cke_o = 1'b1;
      odt_o = 1'b0;
      lmask_o = 1'b0;
      umask_o = 1'b0;
      ca_o = 21'h1FFFFF;
      forever #16 link_clk_o = ~link_clk_o;
   end

   // levels change off the clock edge; clock enable is driven low here for power down entry, and by issue for self refresh entry
   task automatic pins(input logic rst_n, input logic cke, input logic odt);
      @(negedge link_clk_o);
      reset_n_o = rst_n;
      cke_o = cke;
      odt_o = odt;
   endtask : pins

   // one command for one cycle, then deselect with a changing pattern
   task automatic issue(input logic cs_n, input logic cke, input logic [2:0] code,
      input logic [2:0] bank, input logic [13:0] addr);
      @(negedge link_clk_o);
      cke_o = cke;
      ca_o = {cs_n, code, bank, addr};
      @(negedge link_clk_o);
      ca_o = {1'b1, ~code, ~bank, ~addr};
   endtask : issue

   // termination mode write keeps the termination_strobe bit at zero
   task automatic mrs_term(input logic en);
      issue(1'b0, 1'b1, DDRCI_CMD_MRS, DDRCI_MR_IDX_ODT, {11'h000, en, 2'h0});
   endtask : mrs_term

   // masks {upper,lower} set ahead of each strobe edge, changed while the strobe is high
   task automatic beats(input logic [1:0] rise_m, input logic [1:0] fall_m);
      @(negedge link_clk_o);
      {umask_o, lmask_o} = rise_m;
      #4 strobe_clk_o = 1'b1;
      #4 {umask_o, lmask_o} = fall_m;
      #4 strobe_clk_o = 1'b0;
      #4 {umask_o, lmask_o} = ~fall_m;
   endtask : beats
endmodule : ddrci_ctrl_model

// File: bench/ddrci_top_tb.sv
/*
 testbench for the command input block: makes the core clock and reset,
 drives the link through the controller model and judges the outputs.
 assumes the controller model beside it.
*/
`timescale 1ns/1ns
module ddrci_top_tb
   import ddrci_pkg::*;
;
   logic mclk_i, srst_i, link_clk, strobe_clk, reset_n, cke, odt, lmask, umask;
   logic link_active, buffers_on, term_on, term_pins, in_reset;
   logic [3:0] beat_keep;
   logic [1:0] power_state;
   logic [7:0] bank_open;
   ddrci_ca_t ca;
   ddrci_cmd_t cmd;
   int error_cnt = 0;
   int comparisons = 0;

   // core clock, 8 ns
   initial
   begin
      mclk_i = 1'b0;
      forever #4 mclk_i = ~mclk_i;
   end

   ddrci_ctrl_model u_ddrci_ctrl_model (.link_clk_o(link_clk), .strobe_clk_o(strobe_clk), .reset_n_o(reset_n),
      .cke_o(cke), .odt_o(odt), .ca_o(ca), .lmask_o(lmask), .umask_o(umask));
   ddrci_top u_ddrci_top (.mclk_i(mclk_i), .srst_i(srst_i), .link_clk_i(link_clk), .strobe_clk_i(strobe_clk),
      .reset_n_i(reset_n), .cke_i(cke), .odt_i(odt), .ca_i(ca), .lower_byte_write_mask_i(lmask),
      .upper_byte_write_mask_i(umask), .cmd_o(cmd), .beat_keep_o(beat_keep), .link_active_o(link_active),
      .buffers_on_o(buffers_on), .term_on_o(term_on), .term_data_pins_o(term_pins), .bank_open_o(bank_open),
      .power_state_o(power_state), .in_reset_o(in_reset));

   // compare and count
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   // counts, verdict, end of run
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : finish_test

   // lets level crossings land
   task automatic settle;
      repeat (4) @(negedge link_clk);
   endtask : settle

   // one command, bounded wait for its report
   task automatic do_cmd(input logic [2:0] code, input logic [2:0] bank, input logic [13:0] addr);
      int n;
      n = 0;
      u_ddrci_ctrl_model.issue(1'b0, 1'b1, code, bank, addr);
      while (cmd.valid !== 1'b1 && n < 12)
      begin
         @(negedge mclk_i);
         n++;
      end
      if (cmd.valid !== 1'b1)
      begin
         error_cnt++;
         finish_test();
      end
      check("code", cmd.code, code);
      check("bank", cmd.bank, bank);
      check("addr", cmd.addr, addr);
   endtask : do_cmd

   // device reset held, then released
   task automatic t_reset;
      check("in_reset", in_reset, 1'b1);
      u_ddrci_ctrl_model.pins(1'b1, 1'b1, 1'b0);
      settle();
      check("in_reset", in_reset, 1'b0);
      check("active", link_active, 1'b1);
      check("buffers", buffers_on, 1'b1);
      $display("done reset");
   endtask : t_reset

   // access fields, bank map, deselected command
   task automatic t_decode;
      do_cmd(DDRCI_CMD_ACT, 3'h3, 14'h1ABC);
      do_cmd(DDRCI_CMD_WR, 3'h3, 14'h1010);
      check("ap", cmd.auto_pre, 1'b0);
      check("chop", cmd.chop, 1'b0);
      do_cmd(DDRCI_CMD_RD, 3'h3, 14'h0408);
      check("ap", cmd.auto_pre, 1'b1);
      check("chop", cmd.chop, 1'b1);
      settle();
      check("open", bank_open, 8'h00);
      u_ddrci_ctrl_model.issue(1'b1, 1'b1, DDRCI_CMD_ACT, 3'h7, 14'h0000);
      do_cmd(DDRCI_CMD_ACT, 3'h3, 14'h0001);
      do_cmd(DDRCI_CMD_ACT, 3'h5, 14'h0002);
      settle();
      check("open", bank_open, 8'h28);
      do_cmd(DDRCI_CMD_PRE, 3'h3, 14'h0000);
      settle();
      check("open", bank_open, 8'h20);
      $display("done decode");
   endtask : t_decode

   // power-down kinds and self refresh
   task automatic t_power;
      u_ddrci_ctrl_model.pins(1'b1, 1'b0, 1'b0);
      settle();
      check("state", power_state, 2'h1);
      check("buffers", buffers_on, 1'b0);
      u_ddrci_ctrl_model.pins(1'b1, 1'b1, 1'b0);
      settle();
      check("state", power_state, 2'h0);
      do_cmd(DDRCI_CMD_PRE, 3'h0, 14'h0400);
      settle();
      check("open", bank_open, 8'h00);
      u_ddrci_ctrl_model.pins(1'b1, 1'b0, 1'b0);
      settle();
      check("state", power_state, 2'h2);
      u_ddrci_ctrl_model.pins(1'b1, 1'b1, 1'b0);
      u_ddrci_ctrl_model.issue(1'b0, 1'b0, DDRCI_CMD_REF, 3'h0, 14'h0000);
      settle();
      check("state", power_state, 2'h3);
      check("buffers", buffers_on, 1'b0);
      u_ddrci_ctrl_model.pins(1'b1, 1'b1, 1'b0);
      settle();
      check("state", power_state, 2'h0);
      $display("done power");
   endtask : t_power

   // termination gating and byte masks
   task automatic t_term_mask;
      u_ddrci_ctrl_model.pins(1'b1, 1'b1, 1'b1);
      settle();
      check("term", term_on, 1'b0);
      u_ddrci_ctrl_model.mrs_term(1'b1);
      settle();
      check("term", term_on, 1'b1);
      check("term_pins", term_pins, 1'b1);
      u_ddrci_ctrl_model.pins(1'b1, 1'b1, 1'b0);
      settle();
      check("term", term_on, 1'b0);
      u_ddrci_ctrl_model.beats(2'h1, 2'h0);
      settle();
      check("keep", beat_keep, 4'hE);
      u_ddrci_ctrl_model.beats(2'h0, 2'h2);
      settle();
      check("keep", beat_keep, 4'h7);
      $display("done term_mask");
   endtask : t_term_mask

   // reset in mid-run drops open rows
   task automatic t_rst;
      do_cmd(DDRCI_CMD_ACT, 3'h1, 14'h0000);
      u_ddrci_ctrl_model.pins(1'b0, 1'b1, 1'b0);
      settle();
      check("in_reset", in_reset, 1'b1);
      check("open", bank_open, 8'h00);
      u_ddrci_ctrl_model.pins(1'b1, 1'b1, 1'b0);
      settle();
      check("in_reset", in_reset, 1'b0);
      $display("done rst");
   endtask : t_rst

   // main sequence
   initial
   begin
      srst_i = 1'b1;
      repeat (2) @(negedge mclk_i);
      srst_i = 1'b0;
      t_reset();
      t_decode();
      t_power();
      t_term_mask();
      t_rst();
      finish_test();
   end
endmodule : ddrci_top_tb
